// File: hw/iafp_consts.vh
// Constants for the in-application flash programming block
`ifndef IAFP_CONSTS_VH
`define IAFP_CONSTS_VH
`define IAFP_ADDR_CFG      8'hB1
`define IAFP_ADDR_CMD      8'hB2
`define IAFP_ADDR_ADRL     8'hB3
`define IAFP_ADDR_ADRH     8'hB4
`define IAFP_ADDR_DATA     8'hB5
`define IAFP_ADDR_STAT     8'hB6
`define IAFP_RST_BYTE      8'h00
`define IAFP_BIT_EN        6
`define IAFP_BIT_IRQSEL    7
`define IAFP_BIT_BUSY      2
`define IAFP_BIT_DBL       3
`define IAFP_UPPER_HI      8'h20
`define IAFP_CMD_PROG      7'h6E
`define IAFP_CMD_READ      7'h0C
`define IAFP_CMD_BERASE    7'h0D
`define IAFP_CMD_SERASE    7'h0B
`define IAFP_CMD_CERASE    7'h01
`define IAFP_CMD_SC0       7'h0F
`define IAFP_CMD_DBL       7'h0E
`define IAFP_LOCK_TOP      3'b000
`define IAFP_BANK_MSB      1
`define IAFP_BANK_LSB      0
`define IAFP_BANK_SPLIT    2'b00
`endif

// File: hw/iafp_top.v
// In-application flash programming sequencer: mailboxes, status and command launch
`timescale 1ns/1ps
`include "iafp_consts.vh"
// Overview of operation
// - Address high mailbox at B4H, resets zero
// - Data mailbox at B5H, resets zero
// - Status bit 2 shows busy
// - Status bits 7..5 show inverted locks
// - Status bit 3 shows six-clock mode
// - Commands ignored while enable bit clear
// - Upper-block code programs lower block only
// - Lower-block code, bank 00, targets upper
// - External code resolves by address and bank
// - Only command register write launches operation
// - Locked target block refuses command except chip erase
// - Startup-config command changes bit zero only
// - Six-clock command switches machine cycle length
// - No block-select commands in application
// - Code reads of busy block fail
// - Completion interrupt when command bit seven set
// - Interrupt pin ignored while interrupt completion
// - Chip erase needs external code, not top lock
module iafp_top
(
  // Clock, reset and special function register bus
  input  wire        clk_i,
  input  wire        rst_n_i,
  input  wire [7:0]  sfr_addr_i,
  input  wire        sfr_wr_i,
  input  wire        sfr_rd_i,
  input  wire [7:0]  sfr_wdata_i,
  output reg  [7:0]  sfr_rdata_o,
  // Fetch context, lock state and stored configuration
  input  wire        internal_fetch_select_n_i,
  input  wire [15:0] exec_addr_i,
  input  wire [2:0]  lock_bits_i,
  input  wire        lock_upper_i,
  input  wire        lock_lower_i,
  input  wire        startup_config_zero_i,
  // Core code reads and the interrupt one pin
  input  wire        code_read_i,
  input  wire        code_read_upper_i,
  input  wire        external_interrupt_one_pin_n_i,
  // Flash array handshake
  input  wire        array_done_i,
  output reg         array_start_o,
  output reg  [6:0]  array_cmd_o,
  output reg         array_upper_o,
  output reg  [15:0] array_addr_o,
  output reg  [7:0]  array_wdata_o,
  // Levels and strobes seen by the core
  output reg         startup_config_zero_o,
  output reg         boot_block_select_o,
  output reg         double_speed_o,
  output reg         code_read_fail_o,
  output reg         external_interrupt_one_o,
  output reg         ext_int_pin_o
);

  reg  [7:0] cfg_q;
  reg  [7:0] cmd_q;
  reg  [7:0] adrl_q;
  reg  [7:0] adrh_q;
  reg  [7:0] data_q;
  reg        busy_q;
  reg        busy_upper_q;
  reg        dbl_q;
  reg        sc0_q;
  reg        boot_sel_q;
  reg        boot_caught_q;

  // Target resolution from fetch pin, bank select and executing address
  // The executing address only matters for internal fetch; external code
  // is never inside either block, so with bank 00 it may reach both of them
  reg  tgt_upper;
  reg  tgt_valid;
  wire exec_upper = exec_addr_i[15:8] >= `IAFP_UPPER_HI;
  wire addr_upper = adrh_q >= `IAFP_UPPER_HI;
  wire bank_split = cfg_q[`IAFP_BANK_MSB:`IAFP_BANK_LSB] == `IAFP_BANK_SPLIT;
  always @*
  begin
    tgt_upper = 1'b1;
    tgt_valid = 1'b1;
    if (!internal_fetch_select_n_i)
    begin
      // External code: address decides only when the bank field is split
      if (bank_split)
        tgt_upper = addr_upper;
      else
        tgt_upper = 1'b1;
    end
    else if (bank_split && !exec_upper)
      tgt_upper = 1'b1;
    else
    begin
      // Code in the upper block may only touch the lower one
      tgt_upper = 1'b0;
      tgt_valid = !addr_upper;
    end
  end

  // Command decode; block-select codes are not listed, so they read as unknown
  wire       cmd_wr    = sfr_wr_i && (sfr_addr_i == `IAFP_ADDR_CMD);
  wire [6:0] cmd_code  = sfr_wdata_i[6:0];
  wire       is_cerase = cmd_code == `IAFP_CMD_CERASE;
  reg        is_known;
  always @*
  begin
    case (cmd_code)
      `IAFP_CMD_PROG:   is_known = 1'b1;
      `IAFP_CMD_READ:   is_known = 1'b1;
      `IAFP_CMD_BERASE: is_known = 1'b1;
      `IAFP_CMD_SERASE: is_known = 1'b1;
      `IAFP_CMD_CERASE: is_known = 1'b1;
      `IAFP_CMD_SC0:    is_known = 1'b1;
      `IAFP_CMD_DBL:    is_known = 1'b1;
      default:          is_known = 1'b0;
    endcase
  end

  // Acceptance; chip erase skips the block lock and has its own gate instead
  // A refused write leaves every register as it was, so software sees no busy
  wire       blk_lock  = tgt_upper ? lock_upper_i : lock_lower_i;
  wire       cerase_ok = !internal_fetch_select_n_i && (lock_bits_i != `IAFP_LOCK_TOP);
  wire       accept    = cmd_wr && cfg_q[`IAFP_BIT_EN] && !busy_q && is_known &&
                         (is_cerase ? cerase_ok : (tgt_valid && !blk_lock));

  // Configuration and address mailboxes; plain stores with no side effects
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cfg_q  <= `IAFP_RST_BYTE;
      adrl_q <= `IAFP_RST_BYTE;
      adrh_q <= `IAFP_RST_BYTE;
    end
    else
    begin
      if (sfr_wr_i && sfr_addr_i == `IAFP_ADDR_CFG)
        cfg_q <= sfr_wdata_i;
      if (sfr_wr_i && sfr_addr_i == `IAFP_ADDR_ADRL)
        adrl_q <= sfr_wdata_i;
      if (sfr_wr_i && sfr_addr_i == `IAFP_ADDR_ADRH)
        adrh_q <= sfr_wdata_i;
    end
  end

  // Data mailbox; a software write wins over the read-back load in one cycle
  // Limitation: the array returns no byte, so a read command loads the held SFR read data
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
      data_q <= `IAFP_RST_BYTE;
    else if (sfr_wr_i && sfr_addr_i == `IAFP_ADDR_DATA)
      data_q <= sfr_wdata_i;
    else if (busy_q && array_done_i && array_cmd_o == `IAFP_CMD_READ)
      data_q <= sfr_rdata_o;
  end

  // Startup configuration and clock mode; boot selection is strapped once
  // so a later startup-config command only shows after the next reset
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      boot_caught_q <= 1'b0;
      boot_sel_q    <= 1'b0;
      sc0_q         <= 1'b0;
      dbl_q         <= 1'b0;
    end
    else
    begin
      if (!boot_caught_q)
      begin
        boot_caught_q <= 1'b1;
        sc0_q         <= startup_config_zero_i;
        boot_sel_q    <= startup_config_zero_i;
      end
      // Command effects come later in the process, so they win over the strap
      if (accept && cmd_code == `IAFP_CMD_SC0)
        sc0_q <= 1'b1;
      if (accept && cmd_code == `IAFP_CMD_DBL)
        dbl_q <= 1'b1;
    end
  end

  // Command launch and completion; busy rises with the accepted write
  // Accept needs an idle sequencer, so launch and completion never collide
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cmd_q                    <= `IAFP_RST_BYTE;
      busy_q                   <= 1'b0;
      busy_upper_q             <= 1'b0;
      array_start_o            <= 1'b0;
      array_cmd_o              <= 7'h00;
      array_upper_o            <= 1'b0;
      array_addr_o             <= 16'h0000;
      array_wdata_o            <= `IAFP_RST_BYTE;
      external_interrupt_one_o <= 1'b0;
    end
    else
    begin
      array_start_o            <= 1'b0;
      external_interrupt_one_o <= 1'b0;
      if (accept)
      begin
        // Request fields hold until the next accepted command
        cmd_q         <= sfr_wdata_i;
        busy_q        <= 1'b1;
        busy_upper_q  <= tgt_upper;
        array_start_o <= 1'b1;
        array_cmd_o   <= cmd_code;
        array_upper_o <= tgt_upper;
        array_addr_o  <= {adrh_q, adrl_q};
        array_wdata_o <= data_q;
      end
      else if (busy_q && array_done_i)
      begin
        busy_q                   <= 1'b0;
        external_interrupt_one_o <= cmd_q[`IAFP_BIT_IRQSEL];
      end
    end
  end

  // Core-side levels, registered so every output leaves a flip-flop
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      startup_config_zero_o <= 1'b0;
      boot_block_select_o   <= 1'b0;
      double_speed_o        <= 1'b0;
    end
    else
    begin
      startup_config_zero_o <= sc0_q;
      boot_block_select_o   <= boot_sel_q;
      double_speed_o        <= dbl_q;
    end
  end

  // Code reads fail while their block is busy; one cycle late, traded for a flop output
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
      code_read_fail_o <= 1'b0;
    else
      code_read_fail_o <= code_read_i && busy_q && (code_read_upper_i == busy_upper_q);
  end

  // Pin is masked as an interrupt source while a job with completion interrupt chosen is busy
  // It reads inactive then, so a low pin cannot fake a completion
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
      ext_int_pin_o <= 1'b1;
    else if (busy_q && cmd_q[`IAFP_BIT_IRQSEL])
      ext_int_pin_o <= 1'b1;
    else
      ext_int_pin_o <= external_interrupt_one_pin_n_i;
  end

  // Status byte: inverted locks on top, then clock mode and busy; spare bits read zero
  wire [7:0] status_byte;
  assign status_byte[7]               = ~lock_bits_i[0];
  assign status_byte[6]               = ~lock_bits_i[1];
  assign status_byte[5]               = ~lock_bits_i[2];
  assign status_byte[4]               = 1'b0;
  assign status_byte[`IAFP_BIT_DBL]  = dbl_q;
  assign status_byte[`IAFP_BIT_BUSY] = busy_q;
  assign status_byte[1]               = 1'b0;
  assign status_byte[0]               = 1'b0;

  // Read multiplexer; unmapped locations read zero
  reg  [7:0] rd_mux;
  always @*
  begin
    case (sfr_addr_i)
      `IAFP_ADDR_CFG:  rd_mux = cfg_q;
      `IAFP_ADDR_CMD:  rd_mux = cmd_q;
      `IAFP_ADDR_ADRL: rd_mux = adrl_q;
      `IAFP_ADDR_ADRH: rd_mux = adrh_q;
      `IAFP_ADDR_DATA: rd_mux = data_q;
      `IAFP_ADDR_STAT: rd_mux = status_byte;
      default:         rd_mux = `IAFP_RST_BYTE;
    endcase
  end

  // Read data is registered; the value appears the cycle after the read strobe
  // and holds until the next read, so software may sample it late
  always @(posedge clk_i)
  begin
    if (!rst_n_i)
      sfr_rdata_o <= `IAFP_RST_BYTE;
    else if (sfr_rd_i)
      sfr_rdata_o <= rd_mux;
  end

endmodule

// File: test/iafp_properties.sv
// Port-level assertions for the flash sequencer
`timescale 1ns/1ps
module iafp_props (
  input wire       clk_i, rst_n_i, sfr_wr_i, sfr_rd_i, array_start_o, array_done_i, double_speed_o,
  input wire       external_interrupt_one_o, external_interrupt_one_pin_n_i, ext_int_pin_o,
  input wire [7:0] sfr_addr_i, sfr_rdata_o,
  input wire [2:0] lock_bits_i
);
  // Read data is registered, so status fields are tied to causes one cycle back
  wire st_rd = sfr_rd_i && sfr_addr_i == 8'hB6;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  start_pulse_a: assert property (array_start_o |=> !array_start_o) else $error("long start");
  start_cause_a: assert property (array_start_o |-> $past(sfr_wr_i && sfr_addr_i == 8'hB2))
    else $error("stray start");
  busy_read_a: assert property (st_rd && array_start_o |=> sfr_rdata_o[2]) else $error("no busy");
  lock_view_a: assert property (st_rd |=> sfr_rdata_o[7:5] == ~$past({lock_bits_i[0], lock_bits_i[1], lock_bits_i[2]}))
    else $error("bad lock view");
  dbl_view_a: assert property (st_rd |=> sfr_rdata_o[3] == double_speed_o) else $error("bad dbl");
  irq_cause_a: assert property (external_interrupt_one_o |-> $past(array_done_i)) else $error("stray irq");
  irq_pulse_a: assert property (external_interrupt_one_o |=> !external_interrupt_one_o) else $error("long irq");
  pin_free_a: assert property (!ext_int_pin_o |-> !$past(external_interrupt_one_pin_n_i)) else $error("bad pin");
endmodule

// File: test/iafp_array_model.sv
// Behavioural flash array: ends each job after a chosen delay
`timescale 1ns/1ps
module iafp_array_model (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       start_i,
  input  wire [7:0] delay_i,
  output reg        done_o
);
  reg [7:0] cnt_q;
  reg       run_q;
  // Zero delay answers promptly; done is a one-cycle strobe like a real array
  always @(posedge clk_i)
  begin
    done_o <= rst_n_i && run_q && cnt_q == 8'h00;
    run_q  <= rst_n_i && (start_i || (run_q && cnt_q != 8'h00));
    cnt_q  <= start_i ? delay_i : cnt_q - 8'h01;
  end
endmodule

// File: test/iafp_top_tb.sv
// Self-checking bench for the flash sequencer
`timescale 1ns/1ps
module iafp_top_tb;
  localparam [55:0] CMD_CODES = 56'h6E0C0D0B010F0E;
  reg         clk_i = 0, rst_n_i = 0, sfr_wr_i = 0, sfr_rd_i = 0, lock_upper_i = 0, act = 0, up_q, code_read_i = 0;
  reg  [6:0]  c_q;
  reg  [15:0] a_q;
  wire [6:0]  array_cmd_o;
  wire [15:0] array_addr_o;
  wire        startup_config_zero_o, code_read_fail_o;
  reg         internal_fetch_select_n_i = 1, external_interrupt_one_pin_n_i = 1;
  reg  [7:0]  sfr_addr_i = 0, sfr_wdata_i = 0, dly = 0, rd;
  reg  [15:0] exec_addr_i = 0;
  reg  [2:0]  lock_bits_i = 3'h7;
  wire [7:0]  sfr_rdata_o;
  wire        array_done_i, array_start_o, array_upper_o, external_interrupt_one_o, ext_int_pin_o, boot_block_select_o;
  integer     n_mismatch = 0, n_checks = 0, n_start = 0, n_irq = 0, n_pin = 0, n_fail = 0, k;
  iafp_top u_dut (.clk_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o,
    .internal_fetch_select_n_i, .exec_addr_i, .lock_bits_i, .lock_upper_i, .lock_lower_i(1'b0),
    .startup_config_zero_i(1'b0), .code_read_i, .code_read_upper_i(1'b0),
    .external_interrupt_one_pin_n_i, .array_done_i, .array_start_o, .array_cmd_o, .array_upper_o,
    .array_addr_o, .array_wdata_o(), .startup_config_zero_o, .boot_block_select_o,
    .double_speed_o(), .code_read_fail_o, .external_interrupt_one_o, .ext_int_pin_o);
  iafp_array_model u_arr (.clk_i, .rst_n_i, .start_i(array_start_o), .delay_i(dly), .done_o(array_done_i));
  initial forever #2 clk_i = ~clk_i;
  // Count launches and interrupts; the pin must read inactive from a launch with nonzero delay until the completion interrupt
  always @(posedge clk_i)
  begin
    n_start <= n_start + (array_start_o === 1'b1);
    up_q <= array_start_o === 1'b1 ? array_upper_o : up_q;
    c_q <= array_start_o === 1'b1 ? array_cmd_o : c_q;
    a_q <= array_start_o === 1'b1 ? array_addr_o : a_q;
    n_fail <= n_fail + (code_read_fail_o === 1'b1);
    n_irq <= n_irq + (external_interrupt_one_o === 1'b1);
    act <= external_interrupt_one_o !== 1'b1 && (act || (array_start_o === 1'b1 && dly != 0));
    n_pin <= n_pin + (act && ext_int_pin_o !== 1'b1);
  end
  task chk(input [7:0] got, exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task wr(input [7:0] a, d);
  begin
    @(posedge clk_i) {sfr_addr_i, sfr_wdata_i, sfr_wr_i} <= {a, d, 1'b1};
    @(posedge clk_i) sfr_wr_i <= 1'b0;
  end
  endtask
  // Also drops a pending write, so a read may follow a command back to back
  task rdr(input [7:0] a);
  begin
    @(posedge clk_i) {sfr_addr_i, sfr_rd_i, sfr_wr_i} <= {a, 1'b1, 1'b0};
    @(posedge clk_i) sfr_rd_i <= 1'b0;
    #1 rd = sfr_rdata_o;
  end
  endtask
  task cmd(input [7:0] cfg, input f, input [15:0] e, input [7:0] hi, c, input s, input [1:0] u);
    integer n0, i;
  begin
    @(posedge clk_i) {internal_fetch_select_n_i, exec_addr_i} <= {f, e};
    n0 = n_start;
    wr(8'hB4, hi);
    wr(8'hB1, cfg);
    @(posedge clk_i) {sfr_addr_i, sfr_wdata_i, sfr_wr_i} <= {8'hB2, c, 1'b1};
    rdr(8'hB6);
    chk(rd & 8'h04, {5'h0, s, 2'h0});
    for (i = 0; i < 40 && rd[2] !== 1'b0; i = i + 1) rdr(8'hB6);
    chk(rd & 8'h04, 8'h00);
    chk(n_start - n0, s);
    if (s && u < 2'h2) chk(up_q, u);
    if (s) chk(a_q[15:8], hi);
    if (s) chk({1'b0, c_q}, c & 8'h7F);
    $display("command %h done", c);
  end
  endtask
  task conclude;
  begin
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  // A hung handshake must not stall the run
  initial
  begin
    #100000 n_mismatch = n_mismatch + 1;
    conclude;
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (k = 0; k < 2; k = k + 1)
    begin
      rdr(8'hB4 + k[7:0]);
      chk(rd, 8'h00);
      wr(8'hB4 + k[7:0], 8'hA5 + k[7:0]);
      rdr(8'hB4 + k[7:0]);
      chk(rd, 8'hA5 + k[7:0]);
    end
    $display("mailbox test done");
    @(posedge clk_i) lock_bits_i <= 3'h2;
    rdr(8'hB6);
    chk(rd, 8'hA0);
    cmd(8'h00, 1'b1, 16'h3000, 8'h10, 8'h6E, 1'b0, 2'h0);
    cmd(8'h40, 1'b1, 16'h3000, 8'h10, 8'h6E, 1'b1, 2'h0);
    cmd(8'h43, 1'b1, 16'h3000, 8'h30, 8'h6E, 1'b0, 2'h0);
    cmd(8'h40, 1'b1, 16'h1FFF, 8'h10, 8'h6E, 1'b1, 2'h1);
    cmd(8'h40, 1'b0, 16'h0000, 8'h1F, 8'h6E, 1'b1, 2'h0);
    cmd(8'h40, 1'b0, 16'h0000, 8'h20, 8'h6E, 1'b1, 2'h1);
    cmd(8'h42, 1'b0, 16'h0000, 8'h10, 8'h6E, 1'b1, 2'h1);
    @(posedge clk_i) lock_upper_i <= 1'b1;
    cmd(8'h40, 1'b0, 16'h0000, 8'h20, 8'h6E, 1'b0, 2'h0);
    @(posedge clk_i) lock_upper_i <= 1'b0;
    cmd(8'h40, 1'b0, 16'h0000, 8'h10, 8'h55, 1'b0, 2'h0);
    cmd(8'h40, 1'b1, 16'h1FFF, 8'h10, 8'h01, 1'b0, 2'h0);
    @(posedge clk_i) lock_bits_i <= 3'h0;
    cmd(8'h40, 1'b0, 16'h0000, 8'h10, 8'h01, 1'b0, 2'h0);
    @(posedge clk_i) lock_bits_i <= 3'h2;
    for (k = 0; k < 7; k = k + 1) cmd(8'h40, 1'b0, 16'h0000, 8'h10, CMD_CODES[8*k +: 8], 1'b1, 2'h2);
    rdr(8'hB6);
    chk(rd, 8'hA8);
    chk(boot_block_select_o, 8'h00);
    chk(startup_config_zero_o, 8'h01);
    @(posedge clk_i) {external_interrupt_one_pin_n_i, dly, code_read_i} <= {1'b0, 8'h0C, 1'b1};
    cmd(8'h40, 1'b0, 16'h0000, 8'h10, 8'hEE, 1'b1, 2'h0);
    chk(n_irq, 8'h01);
    chk(n_pin, 8'h00);
    chk(ext_int_pin_o, 8'h00);
    chk(n_fail, 8'h0F);
    conclude;
  end
endmodule
bind iafp_top iafp_props u_props (.clk_i, .rst_n_i, .sfr_wr_i, .sfr_rd_i, .array_start_o, .array_done_i,
  .double_speed_o, .external_interrupt_one_o, .external_interrupt_one_pin_n_i, .ext_int_pin_o, .sfr_addr_i,
  .sfr_rdata_o, .lock_bits_i);
